// ===== cgs_regs.svh
// Register map, field positions, reset values and counts of the clock select control.
// Assumes inclusion by the control module, the checker and the bench.
`ifndef CGS_REGS_SVH
`define CGS_REGS_SVH

// Byte offsets on the register bus
`define CGS_OFF_CONTROL     12'h000
`define CGS_OFF_MULTIPLIER  12'h004
`define CGS_OFF_TRIM        12'h008
`define CGS_OFF_DIVIDER     12'h00C
`define CGS_OFF_STAGE       12'h010

// Control register bit positions
`define CGS_BIT_EXT_STABLE  0
`define CGS_BIT_EXT_ENABLE  1
`define CGS_BIT_INT_STABLE  2
`define CGS_BIT_INT_ENABLE  3
`define CGS_BIT_CLK_SELECT  4
`define CGS_BIT_MON_ON      5
`define CGS_BIT_MON_FLAG    6

// Reset values
`define CGS_RST_MULTIPLIER  7'h15
`define CGS_RST_TRIM        8'h80

// Divider limit and external start-up count
`define CGS_DIV_MAX         4'h9
`define CGS_STARTUP_COUNT   4096

`endif

// ===== cgs_pkg.sv
// Types of the clock select control.
// Assumes cgs_regs.svh sits in the include path.
package cgs_pkg;

  // Register selected by an address
  typedef enum logic [2:0] {
    CGS_SEL_CONTROL    = 3'b000,
    CGS_SEL_MULTIPLIER = 3'b001,
    CGS_SEL_TRIM       = 3'b010,
    CGS_SEL_DIVIDER    = 3'b011,
    CGS_SEL_STAGE      = 3'b100,
    CGS_SEL_NONE       = 3'b111
  } cgs_sel_type;

  // Reset-bearing state of the control
  typedef struct packed {
    logic        clk_select;
    logic        int_gen_enable;
    logic        int_gen_stable;
    logic        ext_gen_enable;
    logic        ext_gen_stable;
    logic        monitor_on;
    logic        monitor_flag;
    logic        flag_armed;
    logic        ext_ok_seen;
    logic        int_ok_seen;
    logic        int_off_ok_seen;
    logic        ext_off_ok_seen;
    logic        mon_ok_seen;
    logic [12:0] startup_count;
    logic [6:0]  multiplier_factor;
    logic [7:0]  trim_factor;
    logic [31:0] prdata;
  } cgs_state_type;

  // Oscillator readback, kept through reset
  typedef struct packed {
    logic [3:0] divider_count;
    logic [7:0] stage_count;
  } cgs_osc_type;

endpackage

// ===== cgs_ctrl.sv
// Clock source select control: interlocks, stable flags, multiplier, trim,
// oscillator divider and stage readback, reached over APB.
// Assumes the monitor reports, stop request, loop filter and external tick
// inputs are synchronous to CLK_I.
//
// How it works
// - select 1 routes external clock to the output clock, 0 the internal.
// - select sets only after external on and stable held; clears after internal.
// - select forced 1 when internal clock dead or internal enable 0.
// - select forced 0 when external clock dead, external enable 0, or reset.
// - internal enable clears only after select 1 and monitor off held.
// - internal enable forced 1 while monitor on, select 0, or reset.
// - internal stable flag reads 1 once the generator reports in range.
// - internal stable cleared by dead clock, disable, multiplier/trim write, stop, reset.
// - external enable clears only after select 0 and monitor off held.
// - external enable forced 1 while monitor on or select 1; 0 on reset.
// - external stable sets after 4096 external clock cycles since enable.
// - external stable cleared by dead clock, disable, stop, reset.
// - seven-bit multiplier factor sets the internal clock target.
// - multiplier factor zero behaves as one.
// - multiplier writes ignored while monitor on; resets to 21.
// - eight-bit trim factor, writes ignored while monitor on.
// - trim factor resets to 0x80.
// - four-bit divider count driven by loop filter while internal enabled.
// - divider values above 9 act as 9.
// - stage count driven by loop filter; writes ignored while internal enabled.
// - divider and stage are not touched by reset.
// - stop without keep option stops clocks, monitor and auto switching.
// - monitor on forced 1 by flag; forced 0 by disable, stop, reset.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "cgs_regs.svh"

module cgs_ctrl
  import cgs_pkg::*;
#(
  parameter int STARTUP_COUNT = `CGS_STARTUP_COUNT  // External cycles to stable
) (
  input  wire logic        CLK_I,                // Bus clock
  input  wire logic        RST_N_I,              // Async reset, active low
  input  wire logic        PSEL_I,               // APB select
  input  wire logic        PENABLE_I,            // APB access phase
  input  wire logic        PWRITE_I,             // APB direction
  input  wire logic [11:0] PADDR_I,              // APB byte address
  input  wire logic [31:0] PWDATA_I,             // APB write data
  output logic      [31:0] PRDATA_O,             // APB read data
  output logic             PREADY_O,             // APB ready
  output logic             PSLVERR_O,            // APB error, unmapped
  input  wire logic        INT_CLK_INACTIVE_I,   // Monitor: internal clock dead
  input  wire logic        EXT_CLK_INACTIVE_I,   // Monitor: external clock dead
  input  wire logic        INT_IN_RANGE_I,       // Internal clock near target
  input  wire logic        EXT_CLK_TICK_I,       // One pulse per external cycle
  input  wire logic        STOP_MODE_I,          // Stop mode active
  input  wire logic        STOP_OSC_KEEP_I,      // Option: run clocks in stop
  input  wire logic [3:0]  LOOP_DIVIDER_I,       // Loop filter divider count
  input  wire logic [7:0]  LOOP_STAGE_I,         // Loop filter stage count
  output logic             CLK_SELECT_O,         // 1 external, 0 internal
  output logic             CLOCKS_RUN_O,         // Output clocks running
  output logic             INT_GEN_ENABLE_O,     // Internal generator on
  output logic             EXT_GEN_ENABLE_O,     // External generator on
  output logic             MONITOR_ON_O,         // Clock monitor running
  output logic             MONITOR_FLAG_O,       // Clock monitor saw a dead clock
  output logic      [6:0]  MULTIPLIER_FACTOR_O,  // Effective multiplier, never 0
  output logic      [7:0]  TRIM_FACTOR_O,        // Trim factor
  output logic      [3:0]  DIVIDER_COUNT_O,      // Effective divider, at most 9
  output logic      [7:0]  STAGE_COUNT_O         // Oscillator stage count
);

  // ----------------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------------
  // The start-up counter is 13 bits wide; zero would make
  // the external side stable at once
  if (STARTUP_COUNT < 1 || STARTUP_COUNT > 8191) begin : g_bad_count
    $error("STARTUP_COUNT must lie in 1..8191");
  end

  // Count at which the external side turns stable
  localparam logic [12:0] STARTUP_LIMIT = 13'(STARTUP_COUNT);

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  // Used for both the read mux and the write strobes
  // Unmapped words decode to none and answer an error
  function automatic cgs_sel_type decode(input logic [11:0] addr);
    cgs_sel_type sel;
    sel = CGS_SEL_NONE;
    case (addr)
      `CGS_OFF_CONTROL:    sel = CGS_SEL_CONTROL;
      `CGS_OFF_MULTIPLIER: sel = CGS_SEL_MULTIPLIER;
      `CGS_OFF_TRIM:       sel = CGS_SEL_TRIM;
      `CGS_OFF_DIVIDER:    sel = CGS_SEL_DIVIDER;
      `CGS_OFF_STAGE:      sel = CGS_SEL_STAGE;
      default:             sel = CGS_SEL_NONE;
    endcase
    return sel;
  endfunction

  // Divider values above the top divider count act as the top one
  function automatic logic [3:0] clamp_div(input logic [3:0] value);
    return (value > `CGS_DIV_MAX) ? `CGS_DIV_MAX : value;
  endfunction

  // Control state; oscillator readback kept apart
  cgs_state_type cur;
  cgs_state_type next_cur;
  cgs_osc_type   osc;
  cgs_osc_type   next_osc;

  // Decoded bus request
  cgs_sel_type sel;
  logic        setup_phase;
  logic        wr_access;
  logic        rd_setup;
  logic        wr_control;
  logic        wr_mult;
  logic        wr_trim;
  logic        wr_div;
  logic        wr_stage;

  // Stop and monitor qualifiers
  logic        stop_kill;
  logic        mon_active;
  logic        int_dead;
  logic        ext_dead;

  // Write byte and control readback
  logic [7:0]  wbyte;
  logic [7:0]  control_view;

  // ----------------------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------------------
  // Zero wait states: every access ends in its first access cycle
  // Only the low write byte matters; the rest is dropped
  assign sel         = decode(PADDR_I);
  assign setup_phase = PSEL_I && !PENABLE_I;
  assign wr_access   = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_setup    = setup_phase && !PWRITE_I;
  assign wr_control  = wr_access && (sel == CGS_SEL_CONTROL);
  assign wr_mult     = wr_access && (sel == CGS_SEL_MULTIPLIER);
  assign wr_trim     = wr_access && (sel == CGS_SEL_TRIM);
  assign wr_div      = wr_access && (sel == CGS_SEL_DIVIDER);
  assign wr_stage    = wr_access && (sel == CGS_SEL_STAGE);
  assign wbyte       = PWDATA_I[7:0];
  assign PREADY_O    = 1'b1;
  assign PSLVERR_O   = PSEL_I && PENABLE_I && (sel == CGS_SEL_NONE);

  // ----------------------------------------------------------------------------
  // Stop mode and monitor gating
  // ----------------------------------------------------------------------------
  // Without the keep option, stop freezes clocks and blinds the monitor
  // so no dead report lands while clocks are held low
  assign stop_kill  = STOP_MODE_I && !STOP_OSC_KEEP_I;
  assign mon_active = cur.monitor_on && !stop_kill;
  assign int_dead   = mon_active && INT_CLK_INACTIVE_I;
  assign ext_dead   = mon_active && EXT_CLK_INACTIVE_I;

  // Control register as software sees it
  // Unused bit 7 reads as zero
  always_comb begin
    control_view                      = 8'h00;
    control_view[`CGS_BIT_EXT_STABLE] = cur.ext_gen_stable;
    control_view[`CGS_BIT_EXT_ENABLE] = cur.ext_gen_enable;
    control_view[`CGS_BIT_INT_STABLE] = cur.int_gen_stable;
    control_view[`CGS_BIT_INT_ENABLE] = cur.int_gen_enable;
    control_view[`CGS_BIT_CLK_SELECT] = cur.clk_select;
    control_view[`CGS_BIT_MON_ON]     = cur.monitor_on;
    control_view[`CGS_BIT_MON_FLAG]   = cur.monitor_flag;
  end

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  // Forcing terms use the present values; a write only moves a bit that no
  // force holds, so a blocked write simply leaves the bit as it was
  // Interlocks need the history bit and this cycle both; one cycle of
  // latency after a source settles, traded for glitch immunity
  always_comb begin
    next_cur = cur;
    next_osc = osc;

    // History of the interlock conditions, one bus cycle deep
    // Monitor start needs all four bits at once
    next_cur.ext_ok_seen     = cur.ext_gen_enable && cur.ext_gen_stable;
    next_cur.int_ok_seen     = cur.int_gen_enable && cur.int_gen_stable;
    next_cur.int_off_ok_seen = cur.clk_select && !cur.monitor_on;
    next_cur.ext_off_ok_seen = !cur.clk_select && !cur.monitor_on;
    next_cur.mon_ok_seen     = cur.int_gen_enable && cur.int_gen_stable
                               && cur.ext_gen_enable && cur.ext_gen_stable;

    // Monitor flag: set by a dead clock, cleared by read-then-write-zero
    // The read arms the clear so a write never wipes an unseen report
    if (rd_setup && sel == CGS_SEL_CONTROL && cur.monitor_flag) begin
      next_cur.flag_armed = 1'b1;
    end
    if (wr_control && cur.flag_armed && !wbyte[`CGS_BIT_MON_FLAG]) begin
      next_cur.monitor_flag = 1'b0;
      next_cur.flag_armed   = 1'b0;
    end

    // A new event in the clearing cycle still lands
    if (int_dead || ext_dead) begin
      next_cur.monitor_flag = 1'b1;
    end
    if (!cur.monitor_on) begin
      next_cur.monitor_flag = 1'b0;
      next_cur.flag_armed   = 1'b0;
    end

    // Monitor on: started only with both sources settled;
    // a pending flag pins it on against writes; stop without keep still drops both
    if (wr_control) begin
      if (!wbyte[`CGS_BIT_MON_ON]) begin
        next_cur.monitor_on = 1'b0;
      end else if (cur.mon_ok_seen && next_cur.mon_ok_seen) begin
        next_cur.monitor_on = 1'b1;
      end
    end
    if (cur.monitor_flag) begin
      next_cur.monitor_on = 1'b1;
    end
    if (!cur.int_gen_enable || !cur.ext_gen_enable || stop_kill) begin
      next_cur.monitor_on = 1'b0;
    end

    // Clock select: software moves it only once the target source is ready
    // Forces follow the write, so hardware has the last word
    if (wr_control) begin
      if (wbyte[`CGS_BIT_CLK_SELECT] && cur.ext_ok_seen && next_cur.ext_ok_seen) begin
        next_cur.clk_select = 1'b1;
      end else if (!wbyte[`CGS_BIT_CLK_SELECT] && cur.int_ok_seen && next_cur.int_ok_seen) begin
        next_cur.clk_select = 1'b0;
      end
    end
    // A dead or idle internal side leaves only the external one
    if (int_dead || !cur.int_gen_enable) begin
      next_cur.clk_select = 1'b1;
    end
    // Losing the external clock wins: it leaves the chip on the internal one
    if (ext_dead || !cur.ext_gen_enable) begin
      next_cur.clk_select = 1'b0;
    end

    // Internal generator enable
    // Setting is free; clearing waits for external running
    if (wr_control) begin
      if (wbyte[`CGS_BIT_INT_ENABLE]) begin
        next_cur.int_gen_enable = 1'b1;
      end else if (cur.int_off_ok_seen && next_cur.int_off_ok_seen) begin
        next_cur.int_gen_enable = 1'b0;
      end
    end
    // In use or watched: keep it on
    if (cur.monitor_on || !cur.clk_select) begin
      next_cur.int_gen_enable = 1'b1;
    end

    // External generator enable
    // Clearing waits until nothing depends on it
    if (wr_control) begin
      if (wbyte[`CGS_BIT_EXT_ENABLE]) begin
        next_cur.ext_gen_enable = 1'b1;
      end else if (cur.ext_off_ok_seen && next_cur.ext_off_ok_seen) begin
        next_cur.ext_gen_enable = 1'b0;
      end
    end
    // Same for the external side
    if (cur.monitor_on || cur.clk_select) begin
      next_cur.ext_gen_enable = 1'b1;
    end

    // Multiplier and trim, frozen while the monitor runs
    // A retune under the monitor could look like a dead clock
    if (wr_mult && !cur.monitor_on) begin
      next_cur.multiplier_factor = wbyte[6:0];
    end
    if (wr_trim && !cur.monitor_on) begin
      next_cur.trim_factor = wbyte;
    end

    // Internal stable follows the range judgement unless knocked down
    // Only accepted retunes knock it down
    next_cur.int_gen_stable = INT_IN_RANGE_I;
    if (int_dead || !cur.int_gen_enable || stop_kill
        || (wr_mult && !cur.monitor_on) || (wr_trim && !cur.monitor_on)) begin
      next_cur.int_gen_stable = 1'b0;
    end

    // External start-up count; a delay only, it judges no frequency
    // The counter saturates so the flag never wraps back
    if (!cur.ext_gen_enable || ext_dead || stop_kill) begin
      next_cur.startup_count  = 13'h0000;
      next_cur.ext_gen_stable = 1'b0;
    end else begin
      if (EXT_CLK_TICK_I && cur.startup_count != STARTUP_LIMIT) begin
        next_cur.startup_count = cur.startup_count + 13'h0001;
      end
      next_cur.ext_gen_stable = (next_cur.startup_count == STARTUP_LIMIT);
    end

    // Divider and stage: loop filter owns them while the internal side runs
    // Software writes land only while the loop is idle
    if (cur.int_gen_enable) begin
      next_osc.divider_count = LOOP_DIVIDER_I;
      next_osc.stage_count   = LOOP_STAGE_I;
    end else begin
      if (wr_div) begin
        next_osc.divider_count = wbyte[3:0];
      end
      if (wr_stage) begin
        next_osc.stage_count = wbyte;
      end
    end

    // Read data is captured in the setup cycle
    // so it already stands when the access cycle ends
    if (rd_setup) begin
      case (sel)
        CGS_SEL_CONTROL:    next_cur.prdata = {24'h00_0000, control_view};
        CGS_SEL_MULTIPLIER: next_cur.prdata = {25'h000_0000, cur.multiplier_factor};
        CGS_SEL_TRIM:       next_cur.prdata = {24'h00_0000, cur.trim_factor};
        CGS_SEL_DIVIDER:    next_cur.prdata = {28'h000_0000, osc.divider_count};
        CGS_SEL_STAGE:      next_cur.prdata = {24'h00_0000, osc.stage_count};
        default:            next_cur.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------------
  // Reset values of all control state
  // Constants only; history bits clear with the rest
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cur                   <= '0;
      cur.clk_select        <= 1'b0;
      cur.int_gen_enable    <= 1'b1;
      cur.ext_gen_enable    <= 1'b0;
      cur.multiplier_factor <= `CGS_RST_MULTIPLIER;
      cur.trim_factor       <= `CGS_RST_TRIM;
    end else begin
      cur <= next_cur;
    end
  end

  // The oscillator keeps running through reset, so no reset here
  // Unknown in simulation until the loop filter loads it
  always_ff @(posedge CLK_I) begin
    osc <= next_osc;
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  // Status and control straight from the state register; clocks-run decoded from the stop inputs
  assign PRDATA_O            = cur.prdata;
  assign CLK_SELECT_O        = cur.clk_select;
  assign CLOCKS_RUN_O        = !stop_kill;
  assign INT_GEN_ENABLE_O    = cur.int_gen_enable;
  assign EXT_GEN_ENABLE_O    = cur.ext_gen_enable;
  assign MONITOR_ON_O        = cur.monitor_on;
  assign MONITOR_FLAG_O      = cur.monitor_flag;
  // Zero is treated as one so the target never collapses
  assign MULTIPLIER_FACTOR_O = (cur.multiplier_factor == 7'h00) ? 7'h01 : cur.multiplier_factor;
  assign TRIM_FACTOR_O       = cur.trim_factor;
  // Clamp on the port only; readback shows the raw value
  assign DIVIDER_COUNT_O     = clamp_div(osc.divider_count);
  assign STAGE_COUNT_O       = osc.stage_count;

endmodule

// ===== cgs_ctrl_monitor.sv
// Checker for the clock select control, watching top-level ports only.
// Assumes one clock domain and the register map header in the include path.
`timescale 1ns/1ps
`include "cgs_regs.svh"

module cgs_ctrl_monitor (
  input wire logic        CLK_I,               // Bus clock
  input wire logic        RST_N_I,             // Async reset, active low
  input wire logic        PSEL_I,              // APB select
  input wire logic        PENABLE_I,           // APB access phase
  input wire logic        PWRITE_I,            // APB direction
  input wire logic [11:0] PADDR_I,             // APB byte address
  input wire logic        PSLVERR_O,           // APB error
  input wire logic        STOP_MODE_I,         // Stop mode
  input wire logic        STOP_OSC_KEEP_I,     // Keep clocks in stop
  input wire logic [3:0]  LOOP_DIVIDER_I,      // Loop divider
  input wire logic [7:0]  LOOP_STAGE_I,        // Loop stage
  input wire logic        CLK_SELECT_O,        // Source select
  input wire logic        CLOCKS_RUN_O,        // Clocks running
  input wire logic        INT_GEN_ENABLE_O,    // Internal on
  input wire logic        EXT_GEN_ENABLE_O,    // External on
  input wire logic        MONITOR_ON_O,        // Monitor on
  input wire logic        MONITOR_FLAG_O,      // Monitor flag
  input wire logic [6:0]  MULTIPLIER_FACTOR_O, // Multiplier
  input wire logic [7:0]  TRIM_FACTOR_O,       // Trim
  input wire logic [3:0]  DIVIDER_COUNT_O,     // Divider
  input wire logic [7:0]  STAGE_COUNT_O        // Stage
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  // ----------------------------------------
  // Bus write steps
  // ----------------------------------------
  sequence s_access;
    PSEL_I && PENABLE_I && PWRITE_I;
  endsequence
  sequence s_locked_wr;
    s_access ##0 (PADDR_I == `CGS_OFF_MULTIPLIER || PADDR_I == `CGS_OFF_TRIM) ##0 MONITOR_ON_O;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Locked writes must leave both factors alone and raise no error
  chk_locked_keep: assert property (s_locked_wr |=> $stable(MULTIPLIER_FACTOR_O) && $stable(TRIM_FACTOR_O))
    else $error("locked factor changed");
  chk_locked_noerr: assert property (s_locked_wr |-> !PSLVERR_O)
    else $error("error on locked write");
  chk_stop_run: assert property (CLOCKS_RUN_O == !(STOP_MODE_I && !STOP_OSC_KEEP_I))
    else $error("clock run state wrong");
  chk_mult_nonzero: assert property (MULTIPLIER_FACTOR_O != 7'h00)
    else $error("multiplier shows zero");
  chk_int_forced: assert property (!CLK_SELECT_O |=> INT_GEN_ENABLE_O)
    else $error("internal enable not forced");
  chk_ext_forced: assert property ((CLK_SELECT_O || MONITOR_ON_O) |=> EXT_GEN_ENABLE_O)
    else $error("external enable not forced");
  chk_mon_off: assert property ((!INT_GEN_ENABLE_O || !EXT_GEN_ENABLE_O) |=> !MONITOR_ON_O)
    else $error("monitor not forced off");
  chk_flag_clear: assert property (!MONITOR_ON_O |=> !MONITOR_FLAG_O)
    else $error("flag kept without monitor");
  chk_select_src: assert property ($rose(CLK_SELECT_O) |-> $past(EXT_GEN_ENABLE_O))
    else $error("select set without external on");
  // Loop filter owns divider and stage while the internal generator runs
  chk_loop_follow: assert property (INT_GEN_ENABLE_O |=> STAGE_COUNT_O == $past(LOOP_STAGE_I)
    && DIVIDER_COUNT_O == (($past(LOOP_DIVIDER_I) > 4'h9) ? 4'h9 : $past(LOOP_DIVIDER_I)))
    else $error("loop values not followed");
endmodule

bind cgs_ctrl cgs_ctrl_monitor u_cgs_ctrl_monitor (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PSLVERR_O(PSLVERR_O),
  .STOP_MODE_I(STOP_MODE_I), .STOP_OSC_KEEP_I(STOP_OSC_KEEP_I), .LOOP_DIVIDER_I(LOOP_DIVIDER_I),
  .LOOP_STAGE_I(LOOP_STAGE_I), .CLK_SELECT_O(CLK_SELECT_O), .CLOCKS_RUN_O(CLOCKS_RUN_O),
  .INT_GEN_ENABLE_O(INT_GEN_ENABLE_O), .EXT_GEN_ENABLE_O(EXT_GEN_ENABLE_O), .MONITOR_ON_O(MONITOR_ON_O),
  .MONITOR_FLAG_O(MONITOR_FLAG_O), .MULTIPLIER_FACTOR_O(MULTIPLIER_FACTOR_O), .TRIM_FACTOR_O(TRIM_FACTOR_O),
  .DIVIDER_COUNT_O(DIVIDER_COUNT_O), .STAGE_COUNT_O(STAGE_COUNT_O));

// ===== tb.sv
// Self-checking bench for the clock select control over APB.
// Assumes the register header and package are compiled first.
`timescale 1ns/1ps
`include "cgs_regs.svh"

module tb;
  import cgs_pkg::*;
  logic clk, rst_n, psel, pen, pwr, rdy, err, sel, run, ion, eon, mon, flg;
  logic idead, edead, inrange, tick, stop, keep, perr;
  logic [11:0] addr;
  logic [31:0] wdata, prd, rd;
  logic [3:0]  ldiv, div;
  logic [7:0]  lstg, stg, trim;
  logic [6:0]  mult;
  int errors, comparisons;

  cgs_ctrl #(.STARTUP_COUNT(16)) u_cgs_ctrl (.CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(addr), .PWDATA_I(wdata), .PRDATA_O(prd), .PREADY_O(rdy),
    .PSLVERR_O(err), .INT_CLK_INACTIVE_I(idead), .EXT_CLK_INACTIVE_I(edead), .INT_IN_RANGE_I(inrange),
    .EXT_CLK_TICK_I(tick), .STOP_MODE_I(stop), .STOP_OSC_KEEP_I(keep), .LOOP_DIVIDER_I(ldiv),
    .LOOP_STAGE_I(lstg), .CLK_SELECT_O(sel), .CLOCKS_RUN_O(run), .INT_GEN_ENABLE_O(ion),
    .EXT_GEN_ENABLE_O(eon), .MONITOR_ON_O(mon), .MONITOR_FLAG_O(flg), .MULTIPLIER_FACTOR_O(mult),
    .TRIM_FACTOR_O(trim), .DIVIDER_COUNT_O(div), .STAGE_COUNT_O(stg));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Hold the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; addr <= a; wdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd = prd;
    perr = err;
    psel <= 1'b0; pen <= 1'b0;
    #1;
  endtask
  // Ticks every other cycle, as the external clock is slower than the bus
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk); tick <= 1'b1;
      @(posedge clk); tick <= 1'b0;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    apb(0, `CGS_OFF_CONTROL, 0);      chk(rd, 32'h0000_000C);
    apb(0, `CGS_OFF_MULTIPLIER, 0);   chk(rd, 32'h0000_0015);
    apb(0, `CGS_OFF_TRIM, 0);         chk(rd, 32'h0000_0080);
    chk({sel, ion, eon, mon}, 4'b0100);
    chk({div, stg}, 12'h93C);
    apb(1, `CGS_OFF_STAGE, 32'h0000_005A); cyc(1); chk(stg, 8'h3C);
    apb(0, 12'h020, 0); chk(perr, 1'b1); chk(rd, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_select;
    apb(1, `CGS_OFF_CONTROL, 32'h0000_001A); cyc(2); chk({sel, eon}, 2'b01);
    ticks(15); cyc(3); apb(0, `CGS_OFF_CONTROL, 0); chk(rd, 32'h0000_000E);
    ticks(1); cyc(3); apb(0, `CGS_OFF_CONTROL, 0); chk(rd, 32'h0000_000F);
    apb(1, `CGS_OFF_CONTROL, 32'h0000_001A); cyc(2); chk(sel, 1'b1);
    apb(1, `CGS_OFF_CONTROL, 32'h0000_0008); cyc(2); chk({sel, eon}, 2'b01);
    apb(1, `CGS_OFF_CONTROL, 32'h0000_001A); cyc(2); chk(sel, 1'b1);
    $display("test select done");
  endtask
  task automatic t_osc;
    apb(1, `CGS_OFF_CONTROL, 32'h0000_0012); cyc(2); chk(ion, 1'b0);
    apb(0, `CGS_OFF_CONTROL, 0); chk(rd, 32'h0000_0013);
    apb(1, `CGS_OFF_STAGE, 32'h0000_005A); cyc(1); chk(stg, 8'h5A);
    apb(1, `CGS_OFF_DIVIDER, 32'h0000_000B); cyc(1); chk(div, 4'h9);
    apb(0, `CGS_OFF_DIVIDER, 0); chk(rd, 32'h0000_000B);
    apb(1, `CGS_OFF_CONTROL, 32'h0000_001A); cyc(3); chk({ion, stg}, 9'h13C);
    apb(1, `CGS_OFF_MULTIPLIER, 0); cyc(1); chk(mult, 7'h01);
    apb(1, `CGS_OFF_MULTIPLIER, 32'h0000_0015); apb(1, `CGS_OFF_TRIM, 32'h0000_007F);
    cyc(3); chk({mult, trim}, 15'h157F);
    $display("test oscillator done");
  endtask
  task automatic t_monitor;
    apb(1, `CGS_OFF_CONTROL, 32'h0000_003A); cyc(2); chk(mon, 1'b1);
    apb(1, `CGS_OFF_TRIM, 32'h0000_0011); chk(perr, 1'b0);
    apb(1, `CGS_OFF_MULTIPLIER, 32'h0000_0022); cyc(2); chk({mult, trim}, 15'h157F);
    edead <= 1'b1; cyc(4); chk({flg, mon, sel}, 3'b110);
    edead <= 1'b0; apb(0, `CGS_OFF_CONTROL, 0); chk(rd, 32'h0000_006E);
    apb(1, `CGS_OFF_CONTROL, 32'h0000_003A); cyc(1); chk(flg, 1'b0);
    idead <= 1'b1; cyc(3); chk({flg, mon, sel}, 3'b111);
    idead <= 1'b0;
    stop <= 1'b1; cyc(4); chk({run, mon, flg}, 3'b000);
    apb(0, `CGS_OFF_CONTROL, 0); chk(rd, 32'h0000_001A);
    keep <= 1'b1; cyc(2); chk(run, 1'b1);
    stop <= 1'b0; keep <= 1'b0;
    $display("test monitor done");
  endtask

  task automatic final_report;
    $display("compared %0d, mismatched %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, stimulus and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rst_n, psel, pen, pwr, idead, edead, tick, stop, keep} = '0;
    inrange = 1'b1; addr = '0; wdata = '0; ldiv = 4'hC; lstg = 8'h3C;
    errors = 0; comparisons = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    t_reset; t_select; t_osc; t_monitor;
    final_report;
  end
  initial begin
    #400_000;
    errors++;
    final_report;
  end
endmodule
